// ---- bench/tpc_checker.sv ----
// Purpose: Port-level assertions for the timer prescaler block
// Assumes: Option byte static while out of reset
// Notes:   Bound to tpc_timer from the testbench
`timescale 1ns/1ps
`include "tpc_defs.svh"
// ****************************************
// Checker
// ****************************************
module tpc_checker (
    // Clock and reset
    input wire logic                 CLK_I,
    input wire logic                 RSTN_I,
    // Bus and pins
    input wire tpc_pkg::tpc_wb_req_t WB_REQ_I,
    input wire tpc_pkg::tpc_wb_rsp_t WB_RSP_O,
    input wire logic [7:0]           OPTION_I,
    input wire logic                 TIMER_PIN_I,
    input wire logic                 TIMER_IRQ_O,
    input wire logic                 OSC_RC_O
);
    import tpc_pkg::*;
    logic rd_ack;
    logic rd_ctl;
    logic mapped;
    assign rd_ack = WB_RSP_O.ack && !WB_REQ_I.we;
    assign rd_ctl = rd_ack && WB_REQ_I.adr == `TPC_ADDR_CONTROL;
    assign mapped = WB_REQ_I.adr inside {`TPC_ADDR_CONTROL, `TPC_ADDR_COUNTER, `TPC_ADDR_OPTION};
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    bus_answer_a: assert property (WB_REQ_I.cyc && WB_REQ_I.stb && !WB_RSP_O.ack
        && !WB_RSP_O.err && $past(RSTN_I) |=> WB_RSP_O.ack || WB_RSP_O.err)
        else $error("bus request not answered in one cycle");
    ack_pulse_a: assert property (WB_RSP_O.ack |=> !WB_RSP_O.ack)
        else $error("ack longer than one cycle");
    err_map_a: assert property (WB_RSP_O.ack || WB_RSP_O.err |-> WB_RSP_O.err == !mapped)
        else $error("error response on wrong address");
    osc_type_a: assert property ($past(RSTN_I, 2) |-> OSC_RC_O == OPTION_I[7])
        else $error("oscillator type differs from option");
    irq_mask_a: assert property (rd_ctl |-> TIMER_IRQ_O == (WB_RSP_O.dat[7] && !WB_RSP_O.dat[6]))
        else $error("interrupt differs from flag and mask");
    opt_bits_a: assert property (rd_ctl && OPTION_I[6] |-> WB_RSP_O.dat[5:0] == 6'h3F)
        else $error("option mode control bits not one");
    clr_read_a: assert property (rd_ctl && !OPTION_I[6] |-> !WB_RSP_O.dat[3])
        else $error("prescaler clear bit reads one");
    opt_read_a: assert property (rd_ack && WB_REQ_I.adr == `TPC_ADDR_OPTION
        |-> WB_RSP_O.dat == {24'h0, OPTION_I}) else $error("option byte read wrong");
endmodule : tpc_checker

// ---- bench/tpc_pin_model.sv ----
// Purpose: External timer pin source
// Assumes: Pulses are 4 cycles high, 4 low
// Notes:   Idles low between bursts
`timescale 1ns/1ps
// ****************************************
// Pin model
// ****************************************
module tpc_pin_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] n_i,
    output logic            pin_o,
    output logic            busy_o
);
    logic [7:0] left_q;
    logic [1:0] ph_q;
    logic       go_q;
    initial begin
        pin_o = 1'b0; left_q = 8'h00; ph_q = 2'h0; go_q = 1'b0;
    end
    assign busy_o = left_q != 8'h00;
    // Period of eight clocks keeps the pin at or below clk/8
    always @(posedge clk_i) begin
        go_q <= go_i;
        if (go_i && !go_q) begin
            left_q <= n_i;
            ph_q   <= 2'h0;
        end else if (busy_o) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h3) begin
                pin_o <= ~pin_o;
                if (pin_o) left_q <= left_q - 8'h01;
            end
        end
    end
endmodule : tpc_pin_model

// ---- bench/tpc_timer_tb.sv ----
// Purpose: Self-checking bench for the timer prescaler block
// Assumes: One idle cycle between bus accesses
// Notes:   Software and option byte modes
`timescale 1ns/1ps
`include "tpc_defs.svh"
// ****************************************
// Testbench
// ****************************************
module tpc_timer_tb;
    import tpc_pkg::*;
    logic        clk, rstn, pin, go, busy, irq, osc;
    logic [7:0]  opt, npl, rd;
    tpc_wb_req_t req;
    tpc_wb_rsp_t rsp;
    int          err_total = 0;
    int          tests_run = 0;
    int          n;
    tpc_timer tpc_timer_inst (.CLK_I(clk), .RSTN_I(rstn), .WB_REQ_I(req), .WB_RSP_O(rsp),
        .OPTION_I(opt), .TIMER_PIN_I(pin), .TIMER_IRQ_O(irq), .OSC_RC_O(osc));
    tpc_pin_model tpc_pin_model_inst (.clk_i(clk), .go_i(go), .n_i(npl), .pin_o(pin),
        .busy_o(busy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic chk_rng(input int g, input int lo, input int hi);
        tests_run++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
        end
    endtask : chk_rng
    task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
        req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
        // Hold the request until ack or err is sampled high; the watchdog ends a hang
        do @(posedge clk); while (!(rsp.ack || rsp.err));
        rd = rsp.err ? 8'hEE : rsp.dat[7:0];
        req <= '0;
        @(posedge clk);
    endtask : bus
    task automatic do_reset(input logic [7:0] o);
        rstn <= 1'b0;
        opt  <= o;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        // Option capture, then the registered status output settles
        repeat (3) @(posedge clk);
    endtask : do_reset
    task automatic pulses(input logic [7:0] k);
        npl <= k;
        go  <= 1'b1;
        repeat (2) @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : pulses
    initial begin
        #400000;
        err_total++;
        stop_test();
    end
    initial begin
        req = '0; rstn = 1'b0; opt = 8'h00; go = 1'b0; npl = 8'h00;
        @(posedge clk);
        do_reset(8'h35);
        bus(0, `TPC_ADDR_CONTROL, 0); chk(rd, 8'h75);
        bus(1, `TPC_ADDR_OPTION, 8'hFF);
        bus(0, `TPC_ADDR_OPTION, 0); chk(rd, 8'h35);
        bus(0, 14'h0010, 0); chk(rd, 8'hEE);
        chk({7'h0, osc}, 8'h00);
        for (int d = 0; d < 8; d++) begin
            bus(1, `TPC_ADDR_CONTROL, {5'b00001, d[2:0]});
            bus(1, `TPC_ADDR_COUNTER, 8'h02);
            n = 0;
            while (irq !== 1'b1 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            chk_rng(n, (4 << d) - 2, (8 << d) + 4);
            bus(0, `TPC_ADDR_CONTROL, 0); chk(rd, {5'b10000, d[2:0]});
        end
        bus(1, `TPC_ADDR_CONTROL, 8'hC8); chk({7'h0, irq}, 8'h00);
        bus(0, `TPC_ADDR_CONTROL, 0); chk(rd, 8'hC0);
        bus(1, `TPC_ADDR_CONTROL, 8'h48);
        bus(0, `TPC_ADDR_CONTROL, 0); chk(rd, 8'h40);
        for (int m = 0; m < 2; m++) begin
            bus(1, `TPC_ADDR_CONTROL, m ? 8'h58 : 8'h68);
            bus(1, `TPC_ADDR_COUNTER, 8'h05);
            repeat (100) @(posedge clk);
            bus(0, `TPC_ADDR_COUNTER, 0); chk(rd, 8'h05);
        end
        bus(1, `TPC_ADDR_CONTROL, 8'h58);
        bus(1, `TPC_ADDR_COUNTER, 8'h20);
        pulses(8'h0A);
        bus(0, `TPC_ADDR_COUNTER, 0); chk_rng(rd, 8'h15, 8'h17);
        bus(1, `TPC_ADDR_CONTROL, 8'h78);
        bus(1, `TPC_ADDR_COUNTER, 8'h14);
        pulses(8'h0A);
        bus(0, `TPC_ADDR_COUNTER, 0); chk(rd, 8'h0A);
        do_reset(8'hE3);
        chk({7'h0, osc}, 8'h01);
        bus(0, `TPC_ADDR_CONTROL, 0); chk(rd, 8'h7F);
        bus(1, `TPC_ADDR_CONTROL, 8'h00);
        bus(0, `TPC_ADDR_CONTROL, 0); chk(rd, 8'h3F);
        bus(1, `TPC_ADDR_COUNTER, 8'h0A);
        pulses(8'h10);
        bus(0, `TPC_ADDR_COUNTER, 0); chk(rd, 8'h08);
        stop_test();
    end
endmodule : tpc_timer_tb
bind tpc_timer tpc_checker tpc_checker_inst (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .WB_REQ_I(WB_REQ_I), .WB_RSP_O(WB_RSP_O), .OPTION_I(OPTION_I),
    .TIMER_PIN_I(TIMER_PIN_I), .TIMER_IRQ_O(TIMER_IRQ_O), .OSC_RC_O(OSC_RC_O));

// ---- verilog/tpc_defs.svh ----
// Purpose: Offsets, field positions and timing counts of the timer prescaler block
// Assumes: Wishbone word addressing, byte address = 4 * register index
// Notes:   Definitions only
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// ****************************************
// Register indexes and byte addresses
// ****************************************
`define TPC_IDX_CONTROL     12'h009
`define TPC_IDX_COUNTER     12'h008
`define TPC_IDX_OPTION      12'hF38
`define TPC_ADDR_CONTROL    14'h0024
`define TPC_ADDR_COUNTER    14'h0020
`define TPC_ADDR_OPTION     14'h3CE0

// ****************************************
// Control register fields
// ****************************************
`define TPC_CTL_REQ         7
`define TPC_CTL_MASK        6
`define TPC_CTL_SRC         5
`define TPC_CTL_EXTEN       4
`define TPC_CTL_PCLR        3
`define TPC_CTL_DIV_HI      2

// ****************************************
// Option byte fields
// ****************************************
`define TPC_OPT_OSC         7
`define TPC_OPT_TIMER_OPTION_SELECT        6

// ****************************************
// Timing
// ****************************************
`define TPC_INT_DIV         2'h3
`define TPC_EXT_MIN_CYC     4'h8
`define TPC_OPTION_RESET    8'h00

`endif

// ---- verilog/tpc_pkg.sv ----
// Purpose: Types of the timer prescaler block
// Assumes: Nothing beyond the header
// Notes:   Constants live in tpc_defs.svh
package tpc_pkg;

    // ****************************************
    // Bus carriers
    // ****************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [13:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tpc_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] dat;
    } tpc_wb_rsp_t;

    typedef enum logic [1:0] {
        TPC_BUS_IDLE = 2'b01,
        TPC_BUS_ACK  = 2'b10
    } tpc_bus_st_t;

endpackage : tpc_pkg

// ---- verilog/tpc_timer.sv ----
// Purpose: Timer clock source selection, 7-bit prescaler and 8-bit down counter
// Assumes: Option byte value arrives as a static input; pins synchronous to CLK_I
// Notes:   Single clock, slower rates are enable pulses
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "tpc_defs.svh"

// How it works
// - Option bit six clear: control fully software owned
// - Both select bits zero: internal clock, pin ignored
// - Enable one, source zero: internal clock gated by pin
// - Enable zero, source one: prescaler receives no clock
// - Both one: pin edges clock prescaler, slow pin
// - Option mode: bits 0,1,2,5 from option, read one
// - Option mode: enable and clear bits held one
// - Request flag set at zero, cleared by writing zero
// - Mask bit one suppresses the timer interrupt
// - Source bit: external one, internal quarter oscillator zero
// - Enable bit connects pin; reads one in option mode
// - Clear bit resets prescaler, reads zero, option one
// - Select bits divide by two to their value
// - Option byte read-only, reset value zero, kept
// - Option bit seven selects oscillator type output
// - Option mode: only bits six, seven writable
// - Software mode: option bits give initial control values
// - Option bit five selects pin or internal clock
// - Option bits two to zero select prescaler tap
// - Control register eight bits, bit three write-only in software mode
// - Option bit four initial enable in software mode
// - Counter wraps zero to all ones, reads freely
// - Counter loadable by software, counts down
module tpc_timer (
    // Clock and reset
    input  wire logic                 CLK_I,
    input  wire logic                 RSTN_I,
    // Wishbone slave
    input  wire tpc_pkg::tpc_wb_req_t WB_REQ_I,
    output tpc_pkg::tpc_wb_rsp_t      WB_RSP_O,
    // Option byte and timer pin
    input  wire logic [7:0]           OPTION_I,
    input  wire logic                 TIMER_PIN_I,
    // Status outputs
    output logic                      TIMER_IRQ_O,
    output logic                      OSC_RC_O
);
    import tpc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    tpc_bus_st_t  bus_q;
    tpc_wb_rsp_t  rsp_q;
    logic [7:0]   option_q;
    logic         opt_mode;
    logic         req_q;
    logic         mask_q;
    logic         src_q;
    logic         exten_q;
    logic [2:0]   div_q;
    logic         init_q;
    logic [7:0]   count_q;
    logic [6:0]   pre_q;
    logic [1:0]   qdiv_q;
    logic         pin_q;
    logic         src_eff;
    logic         exten_eff;
    logic [2:0]   div_eff;
    logic         int_tick;
    logic         pin_rise;
    logic         pre_tick;
    logic [7:0]   pre_ext;
    logic         tap_pulse;
    logic [7:0]   ctl_rd;
    logic [31:0]  rd_data;
    logic         hit_ctl;
    logic         hit_cnt;
    logic         hit_opt;
    logic         access;
    logic         wr_ctl;
    logic         wr_cnt;
    logic         pclr_wr;

    // ****************************************
    // Option byte capture at reset release
    // ****************************************
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            option_q <= `TPC_OPTION_RESET;
            init_q   <= 1'b1;
        end else if (init_q) begin
            option_q <= OPTION_I;
            init_q   <= 1'b0;
        end
    end

    assign opt_mode = option_q[`TPC_OPT_TIMER_OPTION_SELECT];

    // ****************************************
    // Bus decode
    // ****************************************
    assign access  = WB_REQ_I.cyc && WB_REQ_I.stb && (bus_q == TPC_BUS_IDLE);
    assign hit_ctl = (WB_REQ_I.adr == `TPC_ADDR_CONTROL);
    assign hit_cnt = (WB_REQ_I.adr == `TPC_ADDR_COUNTER);
    assign hit_opt = (WB_REQ_I.adr == `TPC_ADDR_OPTION);
    assign wr_ctl  = access && WB_REQ_I.we && hit_ctl && WB_REQ_I.sel[0] && !init_q;
    assign wr_cnt  = access && WB_REQ_I.we && hit_cnt && WB_REQ_I.sel[0];
    assign pclr_wr = wr_ctl && !opt_mode && WB_REQ_I.dat[`TPC_CTL_PCLR];

    // ****************************************
    // Effective control fields
    // ****************************************
    assign src_eff   = opt_mode ? option_q[`TPC_CTL_SRC] : src_q;
    assign exten_eff = opt_mode ? 1'b1 : exten_q;
    assign div_eff   = opt_mode ? option_q[`TPC_CTL_DIV_HI:0] : div_q;

    assign ctl_rd[`TPC_CTL_REQ]   = req_q;
    assign ctl_rd[`TPC_CTL_MASK]  = mask_q;
    assign ctl_rd[`TPC_CTL_SRC]   = opt_mode ? 1'b1 : src_q;
    assign ctl_rd[`TPC_CTL_EXTEN] = opt_mode ? 1'b1 : exten_q;
    assign ctl_rd[`TPC_CTL_PCLR]  = opt_mode;
    assign ctl_rd[`TPC_CTL_DIV_HI:0] = opt_mode ? 3'h7 : div_q;

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mask_q  <= 1'b1;
            src_q   <= 1'b0;
            exten_q <= 1'b0;
            div_q   <= 3'h0;
        end else if (init_q) begin
            src_q   <= OPTION_I[`TPC_CTL_SRC];
            exten_q <= OPTION_I[`TPC_CTL_EXTEN];
            div_q   <= OPTION_I[`TPC_CTL_DIV_HI:0];
        end else if (wr_ctl) begin
            mask_q <= WB_REQ_I.dat[`TPC_CTL_MASK];
            if (!opt_mode) begin
                src_q   <= WB_REQ_I.dat[`TPC_CTL_SRC];
                exten_q <= WB_REQ_I.dat[`TPC_CTL_EXTEN];
                div_q   <= WB_REQ_I.dat[`TPC_CTL_DIV_HI:0];
            end
        end
    end

    // ****************************************
    // Clock source selection
    // ****************************************
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            qdiv_q <= 2'h0;
            pin_q  <= 1'b0;
        end else begin
            qdiv_q <= qdiv_q + 2'h1;
            pin_q  <= TIMER_PIN_I;
        end
    end

    assign int_tick = (qdiv_q == `TPC_INT_DIV);
    assign pin_rise = TIMER_PIN_I && !pin_q;

    always_comb begin
        unique case ({exten_eff, src_eff})
            2'b00:   pre_tick = int_tick;
            2'b10:   pre_tick = int_tick && TIMER_PIN_I;
            2'b01:   pre_tick = 1'b0;
            default: pre_tick = pin_rise;
        endcase
    end

    // ****************************************
    // Prescaler
    // ****************************************
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pre_q <= 7'h00;
        end else if (pclr_wr) begin
            pre_q <= 7'h00;
        end else if (pre_tick) begin
            pre_q <= pre_q + 7'h01;
        end
    end

    // Tap n pulses when the low n bits roll over
    assign pre_ext = {pre_q, 1'b1};
    assign tap_pulse = pre_tick && !pclr_wr
                       && (&(pre_ext | ~(8'hFF >> (3'h7 - div_eff))));

    // ****************************************
    // Counter and request flag
    // ****************************************
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            count_q <= 8'hFF;
        end else if (wr_cnt) begin
            count_q <= WB_REQ_I.dat[7:0];
        end else if (tap_pulse) begin
            count_q <= count_q - 8'h01;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            req_q <= 1'b0;
        end else if (tap_pulse && !wr_cnt && (count_q == 8'h01)) begin
            req_q <= 1'b1;
        end else if (wr_ctl && !WB_REQ_I.dat[`TPC_CTL_REQ]) begin
            req_q <= 1'b0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            TIMER_IRQ_O <= 1'b0;
            OSC_RC_O    <= 1'b0;
        end else begin
            TIMER_IRQ_O <= req_q && !mask_q;
            OSC_RC_O    <= option_q[`TPC_OPT_OSC];
        end
    end

    // ****************************************
    // Wishbone answer
    // ****************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_ctl) begin
            rd_data[7:0] = ctl_rd;
        end else if (hit_cnt) begin
            rd_data[7:0] = count_q;
        end else if (hit_opt) begin
            rd_data[7:0] = option_q;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bus_q <= TPC_BUS_IDLE;
            rsp_q <= '0;
        end else begin
            unique case (bus_q)
                TPC_BUS_IDLE: begin
                    if (access) begin
                        bus_q     <= TPC_BUS_ACK;
                        rsp_q.ack <= hit_ctl || hit_cnt || hit_opt;
                        rsp_q.err <= !(hit_ctl || hit_cnt || hit_opt);
                        rsp_q.dat <= WB_REQ_I.we ? 32'h0000_0000 : rd_data;
                    end
                end
                TPC_BUS_ACK: begin
                    bus_q <= TPC_BUS_IDLE;
                    rsp_q <= '0;
                end
            endcase
        end
    end

    assign WB_RSP_O = rsp_q;

endmodule : tpc_timer
